// ==== hdl/tpd_pkg.sv ====
/*
 * tpd_pkg: shared types and constants of the type position decoder.
 * Assumes code bit 1 sits in bit 0 of a code word; marking is 1.
 */
`default_nettype none

package tpd_pkg;

   // code word width and bit positions (bit 1 .. bit 5)
   localparam int CODE_W = 5;
   localparam int B1     = 0;
   localparam int B2     = 1;
   localparam int B3     = 2;
   localparam int B4     = 3;
   localparam int B5     = 4;

   // special codes, bit 5 on the left, bit 1 on the right
   localparam logic [4:0] CODE_LTRS  = 5'h1f; // bits 1-5 marking
   localparam logic [4:0] CODE_FIGS  = 5'h1b; // bits 1,2,4,5 marking
   localparam logic [4:0] CODE_SPACE = 5'h04; // bit 3 marking only

   // field values and half offsets within a field
   localparam logic       FIELD_LTRS = 1'h0;  // left half of matrix
   localparam logic       FIELD_FIGS = 1'h1;  // right half of matrix
   localparam logic [2:0] COL_MID    = 3'h3;  // left group counts down from here
   localparam logic [2:0] COL_RIGHT  = 3'h4;  // right group counts up from here

   // phase lengths of one positioning revolution, in clock cycles
   localparam int DRIVE_CYC  = 4;
   localparam int LOCK_CYC   = 2;
   localparam int RETURN_CYC = 4;
   localparam int REV_CYC    = DRIVE_CYC + LOCK_CYC + RETURN_CYC;
   localparam int CNT_W      = 4;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;

   // output FIFO shape
   localparam int FIFO_DEPTH = 4;

   // one decoded print position
   typedef struct packed {
      logic [1:0] row;     // 0 top .. 3 bottom
      logic [2:0] col;     // 0 .. 7 within the field
      logic       field;   // 0 letters, 1 figures
      logic       print;   // strike the hammer
      logic       advance; // step the carriage
   } tpd_pos_t;

   localparam int POS_W = $bits(tpd_pos_t);

   // positioning sequencer, Gray coded from idle through return
   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_FUNC   = 3'h1,
      ST_DRIVE  = 3'h3,
      ST_LOCK   = 3'h2,
      ST_RETURN = 3'h6
   } tpd_state_t;

endpackage

`default_nettype wire

// ==== hdl/tpd_fifo.sv ====
/*
 * tpd_fifo: small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module tpd_fifo #(
   parameter int WIDTH = 7,
   parameter int DEPTH = 4
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             rst,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   ////////////////////////////////////////////////////////////////////////
   // handshake terms; flags come from the held count
   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_ptr];

   // storage write
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // pointers wrap at depth, which need not be a power of two
   always_ff @(posedge clock) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
         end
      end
   end

   // occupancy
   always_ff @(posedge clock) begin
      if (rst) begin
         count <= '0;
      end else if (push && !pop) begin
         count <= count + (AW+1)'(1);
      end else if (pop && !push) begin
         count <= count - (AW+1)'(1);
      end
   end

endmodule

`default_nettype wire

// ==== hdl/tpd_decoder.sv ====
/*
 * tpd_decoder: turns each five-level code from the selector into a row,
 * column and field on a 4 x 16 type matrix, sequencing a function cycle and
 * one positioning revolution per character. Positions leave through a FIFO.
 * Assumes the selector holds code bits stable from raising code_valid until
 * code_ack rises, and drops code_valid before offering the next code.
 */
`timescale 1ns/1ps
`default_nettype none

// How it works
// RQ1: each pick is four rows by eight columns; field picks matrix half.
// RQ2: field changes only on the letters or figures shift code, never printing.
// RQ3: held field bit: figures shows right half, letters left, until next shift.
// RQ4: row from bits 1-2, column group from bit 3, column from bits 4-5.
// RQ5: rows: none top, bit1 second, bit2 third, both bottom.
// RQ6: bit 3 marking picks the left group, spacing the right group.
// RQ7: from centre: none first, bit5 second, bit4 third, both fourth column.
// RQ8: after bits settle, function cycle starts, then positioning cycle.
// RQ9: positioning runs exactly one revolution then stops until next character.
// RQ10: return half recentres and loads next column stops, overlapping next setup.
// RQ11: the selected row is locked briefly while the character is struck.
// RQ12: bit 3 alone is word space: blank position, no print, carriage advances.
// RQ13: marking is 1; row 0-3 top down, column 0-7, field bit out.
module tpd_decoder #(
   parameter int DEPTH = tpd_pkg::FIFO_DEPTH
) (
   // clock and reset
   input  wire logic                         clock,
   input  wire logic                         rst,
   // selector side, asynchronous to this clock
   input  wire logic                         code_valid,
   input  wire logic [tpd_pkg::CODE_W-1:0]   code_bits,
   output logic                              code_ack,
   // cycle timing to the mechanism
   output logic                              func_start,
   output logic                              pos_start,
   output logic                              row_lock,
   output logic                              recentre,
   output logic                              field,
   // decoded positions toward the printer
   output logic                              pos_valid,
   input  wire logic                         pos_ready,
   output tpd_pkg::tpd_pos_t                 pos_out
);

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers: meta stages are read only by the second stage
   logic                       valid_meta;
   logic                       valid_sync;
   logic [tpd_pkg::CODE_W-1:0] bits_meta;
   logic [tpd_pkg::CODE_W-1:0] bits_sync;

   always_ff @(posedge clock) begin
      if (rst) begin
         valid_meta <= 1'h0;
         valid_sync <= 1'h0;
         bits_meta  <= '0;
         bits_sync  <= '0;
      end else begin
         valid_meta <= code_valid;
         valid_sync <= valid_meta;
         bits_meta  <= code_bits;
         bits_sync  <= bits_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // declarations
   tpd_pkg::tpd_state_t        state;
   tpd_pkg::tpd_state_t        next_state;
   logic [tpd_pkg::CNT_W-1:0]  cnt;
   logic [tpd_pkg::CODE_W-1:0] cur_code;   // code being positioned
   logic [tpd_pkg::CODE_W-1:0] pend_code;  // next code, set up early
   logic                       pend;
   logic                       accept;
   logic                       can_take;
   logic                       phase_done;
   logic                       fifo_ready;
   logic                       push;
   logic                       fifo_valid;
   tpd_pkg::tpd_pos_t          fifo_data;
   tpd_pkg::tpd_pos_t          decoded;
   logic                       is_ltrs;
   logic                       is_figs;
   logic                       is_space;

   ////////////////////////////////////////////////////////////////////////
   // code acceptance, four-phase with the selector
   // taking a code in the return half overlaps setup with the recentring
   assign can_take = !pend && ((state == tpd_pkg::ST_IDLE) ||
                               (state == tpd_pkg::ST_RETURN));
   assign accept   = valid_sync && !code_ack && can_take;

   always_ff @(posedge clock) begin
      if (rst) begin
         code_ack <= 1'h0;
      end else if (accept) begin
         code_ack <= 1'h1;
      end else if (!valid_sync) begin
         code_ack <= 1'h0;
      end
   end

   // pending slot; the sequencer empties it when it starts a character
   always_ff @(posedge clock) begin
      if (rst) begin
         pend      <= 1'h0;
         pend_code <= '0;
      end else if (accept) begin
         pend      <= (next_state != tpd_pkg::ST_FUNC); // taken straight into a cycle: slot stays empty
         pend_code <= bits_sync;
      end else if (next_state == tpd_pkg::ST_FUNC && state != tpd_pkg::ST_FUNC) begin
         pend      <= 1'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sequencer: function cycle, then drive, lock, return = one revolution
   always_comb begin
      phase_done = 1'h0;
      unique case (state)
         tpd_pkg::ST_DRIVE:  phase_done = (cnt == 4'(tpd_pkg::DRIVE_CYC - 1));
         tpd_pkg::ST_LOCK:   phase_done = (cnt == 4'(tpd_pkg::LOCK_CYC - 1)) && fifo_ready;
         tpd_pkg::ST_RETURN: phase_done = (cnt == 4'(tpd_pkg::RETURN_CYC - 1));
         default:            phase_done = 1'h0;
      endcase
   end

   always_comb begin
      next_state = state;
      unique case (state)
         // RQ8: settled code first trips the function cycle
         tpd_pkg::ST_IDLE: begin
            if (pend) begin
               next_state = tpd_pkg::ST_FUNC;
            end
         end
         // RQ8: positioning follows the function cycle
         tpd_pkg::ST_FUNC: begin
            next_state = tpd_pkg::ST_DRIVE;
         end
         tpd_pkg::ST_DRIVE: begin
            if (phase_done) begin
               next_state = tpd_pkg::ST_LOCK;
            end
         end
         tpd_pkg::ST_LOCK: begin
            if (phase_done) begin
               next_state = tpd_pkg::ST_RETURN;
            end
         end
         // RQ9: one revolution, then stop unless another code waits
         tpd_pkg::ST_RETURN: begin
            if (phase_done) begin
               next_state = (pend || accept) ? tpd_pkg::ST_FUNC : tpd_pkg::ST_IDLE;
            end
         end
         default: begin
            next_state = tpd_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state <= tpd_pkg::ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // phase counter restarts on every state change; a stalled lock holds its last count
   always_ff @(posedge clock) begin
      if (rst) begin
         cnt <= tpd_pkg::CNT_ZERO;
      end else if (next_state != state) begin
         cnt <= tpd_pkg::CNT_ZERO;
      end else if (!phase_done && state != tpd_pkg::ST_IDLE &&
                   !(state == tpd_pkg::ST_LOCK && cnt == 4'(tpd_pkg::LOCK_CYC - 1))) begin
         cnt <= cnt + tpd_pkg::CNT_ONE;
      end
   end

   // current code taken as the function cycle starts, from the pending slot or from a code accepted that cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         cur_code <= '0;
      end else if (next_state == tpd_pkg::ST_FUNC && state != tpd_pkg::ST_FUNC) begin
         cur_code <= accept ? bits_sync : pend_code;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // mechanism timing outputs, all registered
   always_ff @(posedge clock) begin
      if (rst) begin
         func_start <= 1'h0;
         pos_start  <= 1'h0;
         row_lock   <= 1'h0;
         recentre   <= 1'h0;
      end else begin
         // RQ8: function start, then positioning start
         func_start <= (next_state == tpd_pkg::ST_FUNC) && (state != tpd_pkg::ST_FUNC);
         pos_start  <= (next_state == tpd_pkg::ST_DRIVE) && (state == tpd_pkg::ST_FUNC);
         // RQ11: row held locked through the strike
         row_lock   <= (next_state == tpd_pkg::ST_LOCK);
         // RQ10: return half recentres the rail
         recentre   <= (next_state == tpd_pkg::ST_RETURN);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // decode of the current code
   assign is_ltrs  = (cur_code == tpd_pkg::CODE_LTRS);
   assign is_figs  = (cur_code == tpd_pkg::CODE_FIGS);
   assign is_space = (cur_code == tpd_pkg::CODE_SPACE);

   always_comb begin
      decoded = '0;
      // RQ4 RQ5 row from bits 1 and 2
      decoded.row = {cur_code[tpd_pkg::B2], cur_code[tpd_pkg::B1]};
      // RQ6 RQ7 group from bit 3, column outward from centre
      if (cur_code[tpd_pkg::B3]) begin
         decoded.col = tpd_pkg::COL_MID -
                       {1'h0, cur_code[tpd_pkg::B4], cur_code[tpd_pkg::B5]};
      end else begin
         decoded.col = tpd_pkg::COL_RIGHT +
                       {1'h0, cur_code[tpd_pkg::B4], cur_code[tpd_pkg::B5]};
      end
      // RQ1 RQ13 field picks the matrix half
      decoded.field = field;
      // RQ2 RQ12 shift codes and space print nothing; space still advances
      decoded.print   = !(is_ltrs || is_figs || is_space);
      decoded.advance = !(is_ltrs || is_figs);
   end

   ////////////////////////////////////////////////////////////////////////
   // RQ2 RQ3 field state changes only on the shift codes
   always_ff @(posedge clock) begin
      if (rst) begin
         field <= tpd_pkg::FIELD_LTRS;
      end else if (state == tpd_pkg::ST_FUNC) begin
         if (is_figs) begin
            field <= tpd_pkg::FIELD_FIGS;
         end else if (is_ltrs) begin
            field <= tpd_pkg::FIELD_LTRS;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // RQ11 position leaves at the end of the lock; full FIFO holds the lock
   assign push = (state == tpd_pkg::ST_LOCK) && phase_done;

   tpd_fifo #(
      .WIDTH (tpd_pkg::POS_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clock     (clock),
      .rst       (rst),
      .in_valid  (push),
      .in_ready  (fifo_ready),
      .in_data   (decoded),
      .out_valid (fifo_valid),
      .out_ready (pos_ready),
      .out_data  (fifo_data)
   );

   assign pos_valid = fifo_valid;
   assign pos_out   = fifo_data;

   ////////////////////////////////////////////////////////////////////////
   // checks
   property p_func_then_pos;
      @(posedge clock) disable iff (rst)
      func_start |=> pos_start;
   endproperty
   a_func_then_pos: assert property (p_func_then_pos) // RQ8
      else $error("positioning did not follow function start");

   property p_one_rev;
      @(posedge clock) disable iff (rst)
      pos_start |=> !pos_start [*8];
   endproperty
   a_one_rev: assert property (p_one_rev) // RQ9
      else $error("positioning restarted inside a revolution");

   property p_lock_len;
      @(posedge clock) disable iff (rst)
      $rose(row_lock) |-> row_lock [*2];
   endproperty
   a_lock_len: assert property (p_lock_len) // RQ11
      else $error("row lock shorter than the strike");

   property p_recentre_after_lock;
      @(posedge clock) disable iff (rst)
      $fell(row_lock) |-> recentre;
   endproperty
   a_recentre_after_lock: assert property (p_recentre_after_lock) // RQ10
      else $error("return half did not follow the lock");

   property p_field_shift_only;
      @(posedge clock) disable iff (rst)
      $changed(field) |-> $past(is_ltrs || is_figs);
   endproperty
   a_field_shift_only: assert property (p_field_shift_only) // RQ2
      else $error("field moved without a shift code");

   property p_figs_sets;
      @(posedge clock) disable iff (rst)
      (state == tpd_pkg::ST_FUNC && is_figs) |=> field == tpd_pkg::FIELD_FIGS;
   endproperty
   a_figs_sets: assert property (p_figs_sets) // RQ3
      else $error("figures shift did not select figures");

   property p_space_blank;
      @(posedge clock) disable iff (rst)
      (push && is_space) |-> !decoded.print && decoded.advance && decoded.col == 3'h3;
   endproperty
   a_space_blank: assert property (p_space_blank) // RQ12
      else $error("word space printed or did not advance");

   property p_row_map;
      @(posedge clock) disable iff (rst)
      push |-> decoded.row == {cur_code[1], cur_code[0]};
   endproperty
   a_row_map: assert property (p_row_map) // RQ5
      else $error("row decode wrong");

   property p_group_map;
      @(posedge clock) disable iff (rst)
      push |-> decoded.col[2] == !cur_code[2];
   endproperty
   a_group_map: assert property (p_group_map) // RQ6
      else $error("column group decode wrong");

endmodule

`default_nettype wire

// ==== verif/tpd_selector_model.sv ====
/*
 * tpd_selector_model: behavioural selector that offers five-level codes.
 * Assumes the bench asks for a code with go for one falling edge, and
 * that the decoder answers with a four-phase code_ack level.
 */
`timescale 1ns/1ps
`default_nettype none

module tpd_selector_model (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       rst,
   // bench request
   input  wire logic       go,
   input  wire logic [4:0] code_in,
   output logic            busy,
   // link to the decoder
   output logic            code_valid,
   output logic [4:0]      code_bits,
   input  wire logic       code_ack
);
   logic [1:0] phase;

   assign busy = (phase != 2'h0);

   ////////////////////////////////////////////////////////////////////////
   // four-phase offer; bits toggle outside an offer so stale data shows up
   always @(negedge clock) begin
      if (rst) begin
         phase      <= 2'h0;
         code_valid <= 1'h0;
         code_bits  <= 5'h00;
      end else begin
         case (phase)
            2'h0: begin
               if (go) begin
                  code_valid <= 1'h1;
                  code_bits  <= code_in;
                  phase      <= 2'h1;
               end else begin
                  code_bits <= ~code_bits;
               end
            end
            2'h1: begin
               if (code_ack) begin
                  code_valid <= 1'h0;
                  code_bits  <= ~code_bits; // released, no longer meaningful
                  phase      <= 2'h2;
               end
            end
            default: begin
               code_bits <= ~code_bits;
               if (!code_ack) begin
                  phase <= 2'h0; // next offer only after ack has fallen
               end
            end
         endcase
      end
   end
endmodule

`default_nettype wire

// ==== verif/type_position_decoder_tb.sv ====
/*
 * type_position_decoder_tb: self-checking bench for tpd_decoder.
 * Assumes the selector model in its own file; inputs move at falling edges.
 */
`timescale 1ns/1ps
`default_nettype none

module type_position_decoder_tb;
   logic              clock;
   logic              rst;
   logic              go;
   logic [4:0]        code_in;
   logic              busy;
   logic              code_valid;
   logic [4:0]        code_bits;
   logic              code_ack;
   logic              func_start;
   logic              pos_start;
   logic              row_lock;
   logic              recentre;
   logic              field;
   logic              pos_valid;
   logic              pos_ready;
   tpd_pkg::tpd_pos_t pos_out;
   logic              fld;
   int                err_count;
   int                cmp_count;
   int                cyc;

   tpd_decoder i_dut (.clock(clock), .rst(rst), .code_valid(code_valid),
      .code_bits(code_bits), .code_ack(code_ack), .func_start(func_start),
      .pos_start(pos_start), .row_lock(row_lock), .recentre(recentre),
      .field(field), .pos_valid(pos_valid), .pos_ready(pos_ready),
      .pos_out(pos_out));

   tpd_selector_model i_sel (.clock(clock), .rst(rst), .go(go), .code_in(code_in),
      .busy(busy), .code_valid(code_valid), .code_bits(code_bits),
      .code_ack(code_ack));

   ////////////////////////////////////////////////////////////////////////
   // clock, and a ceiling well above the thousand or so cycles needed
   initial begin
      clock = 1'h0;
      forever #5 clock = ~clock;
   end

   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count = err_count + 1;
         end_sim();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // shared helpers
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
         err_count = err_count + 1;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // expected position for a code in the current field
   function automatic tpd_pkg::tpd_pos_t exp_pos(input logic [4:0] c, input logic f);
      tpd_pkg::tpd_pos_t e;
      e.row     = {c[1], c[0]};
      e.col     = c[2] ? (3'h3 - {c[3], c[4]}) : (3'h4 + {c[3], c[4]});
      e.field   = f;
      e.print   = 1'h1;
      e.advance = 1'h1;
      if (c == 5'h1f || c == 5'h1b) begin
         e.print   = 1'h0;
         e.advance = 1'h0;
      end else if (c == 5'h04) begin
         e.print = 1'h0;
      end
      return e;
   endfunction

   task automatic offer(input logic [4:0] c);
      @(negedge clock);
      code_in <= c;
      go      <= 1'h1;
      @(negedge clock);
      go <= 1'h0;
      if (c == 5'h1f) fld = 1'h0;
      if (c == 5'h1b) fld = 1'h1;
   endtask

   task automatic send(input logic [4:0] c);
      int n;
      offer(c);
      n = 0;
      do begin
         @(negedge clock);
         n = n + 1;
      end while (busy && n < 100);
      check("handshake done", {7'h00, busy}, 8'h00);
   endtask

   task automatic pop(input tpd_pkg::tpd_pos_t e, input logic [4:0] c);
      int n;
      n = 0;
      while (pos_valid !== 1'h1 && n < 50) begin
         @(negedge clock);
         n = n + 1;
      end
      check("pos_valid", {7'h00, pos_valid}, 8'h01);
      check("position", {2'h0, pos_out[7:2]}, {2'h0, e[7:2]});
      check("flags", {6'h00, pos_out[1:0]}, {6'h00, e[1:0]});
      pos_ready <= 1'h1;
      @(negedge clock);
      pos_ready <= 1'h0;
      @(negedge clock);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset();
      check("outputs after reset", {1'h0, code_ack, func_start, pos_start, row_lock,
         recentre, field, pos_valid}, 8'h00);
   endtask

   // one character: function cycle, then one positioning revolution
   task automatic t_timing();
      int k;
      int f_at    = -1;
      int p_at    = -1;
      int p_n     = 0;
      int l_n     = 0;
      int r_n     = 0;
      int l_last  = -1;
      int r_first = -1;
      offer(5'h13);
      for (k = 0; k < 30; k++) begin
         @(negedge clock);
         if (func_start === 1'h1 && f_at < 0) f_at = k;
         if (pos_start === 1'h1) begin
            p_n = p_n + 1;
            p_at = k;
         end
         if (row_lock === 1'h1) begin
            l_n = l_n + 1;
            l_last = k;
         end
         if (recentre === 1'h1) begin
            r_n = r_n + 1;
            if (r_first < 0) r_first = k;
         end
      end
      check("func before pos", 8'(p_at - f_at), 8'h01);
      check("one revolution", 8'(p_n), 8'h01);
      check("lock cycles", 8'(l_n), 8'h02);
      check("return cycles", 8'(r_n), 8'h04);
      check("return after lock", 8'(r_first - l_last), 8'h01);
      check("field held", {7'h00, field}, {7'h00, fld});
      pop(exp_pos(5'h13, fld), 5'h13);
   endtask

   // every code, each non-shift code in both fields, stepping up through the codes and back down
   task automatic t_all_codes();
      int i;
      logic [4:0] c;
      for (i = 0; i < 64; i++) begin
         c = (i < 32) ? 5'(i) : 5'(63 - i);
         send(c);
         // field follows only the shift codes
         check("field level", {7'h00, field}, {7'h00, fld});
         pop(exp_pos(c, fld), c);
      end
   endtask

   // fill the FIFO with the printer stalled, then drain in order
   task automatic t_fifo_full();
      int i;
      logic [4:0] c;
      for (i = 0; i < 5; i++) begin
         send(5'(5'h08 + i));
      end
      repeat (30) @(negedge clock);
      check("lock stretched while full", {7'h00, row_lock}, 8'h01);
      for (i = 0; i < 5; i++) begin
         c = 5'(5'h08 + i);
         pop(exp_pos(c, fld), c);
      end
      repeat (20) @(negedge clock);
      check("fifo drained", {6'h00, pos_valid, row_lock}, 8'h00);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      rst       = 1'h1;
      go        = 1'h0;
      code_in   = 5'h00;
      pos_ready = 1'h0;
      fld       = 1'h0;
      err_count = 0;
      cmp_count = 0;
      cyc       = 0;
      repeat (3) @(negedge clock);
      rst <= 1'h0;
      @(negedge clock);
      t_reset();
      t_timing();
      t_all_codes();
      send(5'h1b);
      pop(exp_pos(5'h1b, fld), 5'h1b);
      t_fifo_full();
      end_sim();
   end
endmodule

`default_nettype wire
